/* File: src/srl_divider.sv */
// Purpose: Periodic one-cycle pulse generator for the latch
// Assumes: Runs on the bus clock, which stands in for the oscillator
// Notes: Counter clears while stopped so the first pulse is prompt
`default_nettype none
`timescale 1ns/100ps
module srl_divider #(
   parameter int DIV_W = srl_pkg::DIV_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [2:0] sel,
   output logic tick
);
   import srl_pkg::*;
   logic [DIV_W-1:0] count_r;
   logic [DIV_W-1:0] count_nxt;
   logic tick_nxt;

   function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] s);
      logic [DIV_W:0] one_hot;
      // Four bits: code 7 plus the offset would wrap in three
      one_hot = (DIV_W+1)'(1) << (4'(s) + 4'(DIV_MIN_EXP));
      return DIV_W'(one_hot - (DIV_W+1)'(1));
   endfunction

   always_comb begin
      count_nxt = run ? count_r + DIV_W'(1) : '0; // [R16]
      tick_nxt = run && ((count_r & div_mask(sel)) == '0); // [R8]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= '0;
         tick <= 1'b0;
      end else begin
         count_r <= count_nxt;
         tick <= tick_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: src/srl_pin_drv.sv */
// Purpose: Registered pin driver with direction gating
// Assumes: Output enable is active low
// Notes: Data is forced low while drive is low to keep the pin quiet; dir_in gates only oe_n
`default_nettype none
`timescale 1ns/100ps
module srl_pin_drv (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic data,
   input wire logic drive,
   input wire logic dir_in,
   output logic pin,
   output logic pin_oe_n
);
   logic pin_nxt;
   logic oe_n_nxt;

   always_comb begin
      pin_nxt = drive ? data : 1'b0;
      oe_n_nxt = !(drive && !dir_in); // [R4]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin <= 1'b0;
         pin_oe_n <= 1'b1;
      end else begin
         pin <= pin_nxt;
         pin_oe_n <= oe_n_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: src/srl_pkg.sv */
// Purpose: Shared constants for the set-reset latch output control block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Offsets, bit positions and counts live only here
// Overview of operation
// R1: Two separate enable bits gate the true and inverted outputs to pins.
// R2: Both outputs may drive their pins at the same time.
// R3: The alternate-pin select moves the inverted output to its other pin.
// R4: Firmware clears a pin's direction bit before its driver turns on.
// R5: Reset leaves the latch state undefined; nothing forces it.
// R6: Firmware sets or resets the latch before enabling any output.
// R7: Control bit 7 enables the latch when 1 and disables it when 0.
// R8: Bits 6..4 pick a one-cycle pulse every 2^(code+2) clock cycles.
// R9: With the latch on and bit 3 set, the true pin shows the latch state.
// R10: With the latch on and bit 2 set, the inverted pin shows its inverse.
// R11: Writing 1 to bit 1 pulses the set input for one clock period.
// R12: Writing 1 to bit 0 pulses the reset input for one clock period.
// R13: The two pulse bits are write-only and always read back as zero.
// R14: Set and reset together leave the latch in the reset state.
// R15: Clock-set and clock-reset enables route divider pulses to the latch.
// R16: The divider is a free-running counter that runs while enabled.
`default_nettype none
package srl_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_PINFN = 8'h08;
   localparam logic [7:0] OFS_DIR = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam int B_LEN = 7;
   localparam int B_DIV_HI = 6;
   localparam int B_DIV_LO = 4;
   localparam int B_TOE = 3;
   localparam int B_IOE = 2;
   localparam int B_SPS = 1;
   localparam int B_SPR = 0;
   localparam int B_CSE = 6;
   localparam int B_CRE = 2;
   localparam int B_ALT = 0;
   localparam int B_DIR_TRUE = 0;
   localparam int B_DIR_INV = 1;
   localparam int B_DIR_ALT = 2;
   localparam int B_ST_Q = 0;
   localparam int B_ST_KNOWN = 1;
   localparam int B_ST_TDRV = 2;
   localparam int B_ST_IDRV = 3;
   localparam logic [2:0] DIV_SEL_RST = 3'h0;
   localparam logic [2:0] DIR_RST = 3'h7;
   localparam int DIV_W = 9;
   localparam int DIV_MIN_EXP = 2;
   typedef enum logic [1:0] {
      SRL_IDLE = 2'b01,
      SRL_ANS = 2'b10
   } srl_bus_st_t;
endpackage
`default_nettype wire

/* File: src/srl_top.sv */
// Purpose: Set-reset latch control register, pulse sources and outputs
// Assumes: APB master keeps the request stable until pready is seen
// Notes: Latch is modelled as a clocked bit, not a true clockless latch
//
// Added by the designer: the address map and the APB slave port.
`default_nettype none
`timescale 1ns/100ps
module srl_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [srl_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic latch_true_pin,
   output logic latch_true_pin_oe_n,
   output logic latch_inverted_pin,
   output logic latch_inverted_pin_oe_n,
   output logic latch_inverted_alt_pin,
   output logic latch_inverted_alt_pin_oe_n
);
   import srl_pkg::*;

   // Control state
   logic latch_enable_r;
   logic latch_enable_nxt;
   logic [2:0] pulse_divider_select_r;
   logic [2:0] pulse_divider_select_nxt;
   logic true_output_enable_r;
   logic true_output_enable_nxt;
   logic inverted_output_enable_r;
   logic inverted_output_enable_nxt;
   logic clock_set_enable_r;
   logic clock_set_enable_nxt;
   logic clock_reset_enable_r;
   logic clock_reset_enable_nxt;
   logic inverted_output_alt_pin_select_r;
   logic inverted_output_alt_pin_select_nxt;
   logic [2:0] pin_direction_control_r;
   logic [2:0] pin_direction_control_nxt;
   logic software_set_pulse_r;
   logic software_set_pulse_nxt;
   logic software_reset_pulse_r;
   logic software_reset_pulse_nxt;

   // Bus state
   srl_bus_st_t bus_st_r;
   srl_bus_st_t bus_st_nxt;
   logic [31:0] prdata_nxt;
   logic pready_nxt;
   logic pslverr_nxt;

   // Latch state
   logic latch_q_r;
   logic latch_q_nxt;
   logic known_r;
   logic known_nxt;

   logic div_tick;
   logic set_in;
   logic rst_in;
   logic wr_take;
   logic ctrl0_wr;
   logic drive_true;
   logic drive_inv;
   logic drive_alt;

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a == OFS_CTRL0) || (a == OFS_CTRL1) || (a == OFS_PINFN) ||
         (a == OFS_DIR) || (a == OFS_STAT);
   endfunction

   function automatic logic [31:0] reg_read(input logic [ADDR_W-1:0] a);
      logic [31:0] v;
      v = 32'h0;
      case (a)
         OFS_CTRL0: begin
            // Pulse bits stay zero here, they are write-only
            v[B_LEN] = latch_enable_r; // [R13]
            v[B_DIV_HI:B_DIV_LO] = pulse_divider_select_r;
            v[B_TOE] = true_output_enable_r;
            v[B_IOE] = inverted_output_enable_r;
         end
         OFS_CTRL1: begin
            v[B_CSE] = clock_set_enable_r;
            v[B_CRE] = clock_reset_enable_r;
         end
         OFS_PINFN: v[B_ALT] = inverted_output_alt_pin_select_r;
         OFS_DIR: v[2:0] = pin_direction_control_r;
         OFS_STAT: begin
            v[B_ST_Q] = latch_q_r;
            v[B_ST_KNOWN] = known_r;
            v[B_ST_TDRV] = !latch_true_pin_oe_n;
            v[B_ST_IDRV] = !latch_inverted_pin_oe_n ||
               !latch_inverted_alt_pin_oe_n;
         end
         default: v = 32'h0;
      endcase
      return v;
   endfunction

   // Writes land only on the edge that sees pready high
   assign wr_take = psel && penable && pready && pwrite && pstrb[0] &&
      is_mapped(paddr);
   assign ctrl0_wr = wr_take && (paddr == OFS_CTRL0);

   // Bus answer: one wait state keeps prdata straight from a flop
   always_comb begin
      bus_st_nxt = bus_st_r;
      prdata_nxt = prdata;
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      case (bus_st_r)
         SRL_IDLE: begin
            if (psel && penable) begin
               bus_st_nxt = SRL_ANS;
               pready_nxt = 1'b1;
               pslverr_nxt = !is_mapped(paddr);
               prdata_nxt = pwrite ? 32'h0 : reg_read(paddr);
            end
         end
         SRL_ANS: begin
            bus_st_nxt = SRL_IDLE;
         end
         default: bus_st_nxt = SRL_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_st_r <= SRL_IDLE;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         bus_st_r <= bus_st_nxt;
         prdata <= prdata_nxt;
         pready <= pready_nxt;
         pslverr <= pslverr_nxt;
      end
   end

   // Register writes and self-clearing pulse bits
   always_comb begin
      latch_enable_nxt = latch_enable_r;
      pulse_divider_select_nxt = pulse_divider_select_r;
      true_output_enable_nxt = true_output_enable_r;
      inverted_output_enable_nxt = inverted_output_enable_r;
      clock_set_enable_nxt = clock_set_enable_r;
      clock_reset_enable_nxt = clock_reset_enable_r;
      inverted_output_alt_pin_select_nxt = inverted_output_alt_pin_select_r;
      pin_direction_control_nxt = pin_direction_control_r;
      software_set_pulse_nxt = 1'b0;
      software_reset_pulse_nxt = 1'b0;
      if (wr_take) begin
         case (paddr)
            OFS_CTRL0: begin
               latch_enable_nxt = pwdata[B_LEN]; // [R7]
               pulse_divider_select_nxt = pwdata[B_DIV_HI:B_DIV_LO]; // [R8]
               true_output_enable_nxt = pwdata[B_TOE]; // [R1]
               inverted_output_enable_nxt = pwdata[B_IOE]; // [R1]
               software_set_pulse_nxt = pwdata[B_SPS]; // [R11]
               software_reset_pulse_nxt = pwdata[B_SPR]; // [R12]
            end
            OFS_CTRL1: begin
               clock_set_enable_nxt = pwdata[B_CSE];
               clock_reset_enable_nxt = pwdata[B_CRE];
            end
            OFS_PINFN: inverted_output_alt_pin_select_nxt = pwdata[B_ALT];
            OFS_DIR: pin_direction_control_nxt = pwdata[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_enable_r <= 1'b0;
         pulse_divider_select_r <= DIV_SEL_RST;
         true_output_enable_r <= 1'b0;
         inverted_output_enable_r <= 1'b0;
         clock_set_enable_r <= 1'b0;
         clock_reset_enable_r <= 1'b0;
         inverted_output_alt_pin_select_r <= 1'b0;
         pin_direction_control_r <= DIR_RST;
         software_set_pulse_r <= 1'b0;
         software_reset_pulse_r <= 1'b0;
      end else begin
         latch_enable_r <= latch_enable_nxt;
         pulse_divider_select_r <= pulse_divider_select_nxt;
         true_output_enable_r <= true_output_enable_nxt;
         inverted_output_enable_r <= inverted_output_enable_nxt;
         clock_set_enable_r <= clock_set_enable_nxt;
         clock_reset_enable_r <= clock_reset_enable_nxt;
         inverted_output_alt_pin_select_r <=
            inverted_output_alt_pin_select_nxt;
         pin_direction_control_r <= pin_direction_control_nxt;
         software_set_pulse_r <= software_set_pulse_nxt;
         software_reset_pulse_r <= software_reset_pulse_nxt;
      end
   end

   srl_divider #(
      .DIV_W(DIV_W)
   ) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .run(latch_enable_r),
      .sel(pulse_divider_select_r),
      .tick(div_tick)
   );

   assign set_in = software_set_pulse_r ||
      (clock_set_enable_r && div_tick); // [R15]
   assign rst_in = software_reset_pulse_r ||
      (clock_reset_enable_r && div_tick); // [R15]

   // Reset wins when both inputs are high
   always_comb begin
      latch_q_nxt = latch_q_r;
      known_nxt = known_r;
      if (latch_enable_r && rst_in) begin
         latch_q_nxt = 1'b0; // [R14]
         known_nxt = 1'b1;
      end else if (latch_enable_r && set_in) begin
         latch_q_nxt = 1'b1;
         known_nxt = 1'b1;
      end
   end

   // No reset on purpose: the state after reset is whatever it was
   always_ff @(posedge pclk) begin
      latch_q_r <= latch_q_nxt; // [R5]
   end

   // Lets firmware see whether it has initialised the latch yet
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         known_r <= 1'b0; // [R6]
      end else begin
         known_r <= known_nxt;
      end
   end

   assign drive_true = latch_enable_r && true_output_enable_r; // [R9] [R2]
   assign drive_inv = latch_enable_r && inverted_output_enable_r &&
      !inverted_output_alt_pin_select_r; // [R10]
   assign drive_alt = latch_enable_r && inverted_output_enable_r &&
      inverted_output_alt_pin_select_r; // [R3]

   srl_pin_drv u_true (
      .pclk(pclk),
      .presetn(presetn),
      .data(latch_q_r),
      .drive(drive_true),
      .dir_in(pin_direction_control_r[B_DIR_TRUE]),
      .pin(latch_true_pin),
      .pin_oe_n(latch_true_pin_oe_n)
   );

   srl_pin_drv u_inv (
      .pclk(pclk),
      .presetn(presetn),
      .data(!latch_q_r),
      .drive(drive_inv),
      .dir_in(pin_direction_control_r[B_DIR_INV]),
      .pin(latch_inverted_pin),
      .pin_oe_n(latch_inverted_pin_oe_n)
   );

   srl_pin_drv u_alt (
      .pclk(pclk),
      .presetn(presetn),
      .data(!latch_q_r),
      .drive(drive_alt),
      .dir_in(pin_direction_control_r[B_DIR_ALT]),
      .pin(latch_inverted_alt_pin),
      .pin_oe_n(latch_inverted_alt_pin_oe_n)
   );

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   rst_dominance_a: assert property ( // [R14]
      latch_enable_r && set_in && rst_in |=> !latch_q_r)
      else $error("set won over reset");

   set_pulse_a: assert property ( // [R11]
      ctrl0_wr && pwdata[B_SPS] |=> software_set_pulse_r ##1
      !software_set_pulse_r)
      else $error("set pulse not one cycle");

   reset_pulse_a: assert property ( // [R12]
      ctrl0_wr && pwdata[B_SPR] && pwdata[B_LEN] |=> ##1 !latch_q_r)
      else $error("reset pulse did not clear latch");

   pulse_read_a: assert property ( // [R13]
      pready && !pslverr && $past(psel) && !$past(pwrite) &&
      $past(paddr) == OFS_CTRL0 |-> prdata[B_SPS:B_SPR] == 2'b00)
      else $error("pulse bits read nonzero");

   div_stop_a: assert property ( // [R7]
      !latch_enable_r |=> !div_tick)
      else $error("divider ticked while disabled");

   div_period_a: assert property ( // [R8]
      (div_tick && latch_enable_r && pulse_divider_select_r == 3'h0) ##1
      (latch_enable_r && pulse_divider_select_r == 3'h0)[*3]
      |=> div_tick)
      else $error("code 0 pulse not every 4th cycle");

   div_width_a: assert property ( // [R16]
      div_tick |=> !div_tick)
      else $error("divider pulse wider than one cycle");

   true_pin_a: assert property ( // [R9]
      drive_true && !pin_direction_control_r[B_DIR_TRUE] |=>
      !latch_true_pin_oe_n && latch_true_pin == $past(latch_q_r))
      else $error("true pin wrong");

   inv_pin_a: assert property ( // [R10]
      drive_inv && !pin_direction_control_r[B_DIR_INV] |=>
      !latch_inverted_pin_oe_n && latch_inverted_pin == !$past(latch_q_r))
      else $error("inverted pin wrong");

   alt_route_a: assert property ( // [R3]
      inverted_output_alt_pin_select_r |=> latch_inverted_pin_oe_n)
      else $error("primary inverted pin driven while moved");

   gate_off_a: assert property ( // [R1]
      !true_output_enable_r |=> latch_true_pin_oe_n)
      else $error("true pin driven while gated off");

   both_on_a: assert property ( // [R2]
      drive_true && drive_inv && pin_direction_control_r == 3'h0 |=>
      !latch_true_pin_oe_n && !latch_inverted_pin_oe_n)
      else $error("outputs not driven together");

   clk_set_a: assert property ( // [R15]
      latch_enable_r && clock_set_enable_r && div_tick && !rst_in
      |=> latch_q_r)
      else $error("divider pulse did not set latch");

   sw_set_c: cover property (software_set_pulse_r && latch_enable_r);
   clk_rst_c: cover property (clock_reset_enable_r && div_tick);
   both_out_c: cover property (
      !latch_true_pin_oe_n && !latch_inverted_pin_oe_n);
   alt_pin_c: cover property (!latch_inverted_alt_pin_oe_n);
endmodule
`default_nettype wire

/* File: verification/srl_top_tb.sv */
// Purpose: Self-checking bench for the latch output control block
// Assumes: APB answers after a bounded wait; pins are registered
// Notes: Divider period is measured between two tick-driven latch sets
`default_nettype none
`timescale 1ns/100ps
module srl_top_tb;
   import srl_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic tq, tq_oe_n, iq, iq_oe_n, aq, aq_oe_n;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   int t1, t2;

   srl_top u_srl_top (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .latch_true_pin(tq),
      .latch_true_pin_oe_n(tq_oe_n),
      .latch_inverted_pin(iq),
      .latch_inverted_pin_oe_n(iq_oe_n),
      .latch_inverted_alt_pin(aq),
      .latch_inverted_alt_pin_oe_n(aq_oe_n)
   );

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
   end

   task automatic summarize;
      $display("Checks %0d, failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Request held until pready is sampled high, then released
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 50) begin
         n_fail++;
         $display("BAD %0t bus hang", $time);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                        input string msg);
      apb(1'b0, a, 32'h0, 4'hf);
      chk(rd, exp, msg);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Order: true pin, oe_n, inverted pin, oe_n, alternate pin, oe_n
   task automatic pins(input logic [5:0] exp, input string msg);
      chk({26'h0, tq, tq_oe_n, iq, iq_oe_n, aq, aq_oe_n}, {26'h0, exp}, msg);
   endtask

   // Bounded wait for the true pin to reach a level; notes the cycle
   task automatic wait_pin(input logic v, output int t);
      int n;
      n = 0;
      @(posedge pclk);
      while (tq !== v && n < 1200) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 1200) begin
         n_fail++;
         $display("BAD %0t pin wait", $time);
      end
      t = cyc;
   endtask

   initial begin
      #2000000;
      n_fail++;
      $display("BAD %0t watchdog", $time);
      summarize;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      rd = '0;
      err = 1'b0;
      idle(5);
      presetn <= 1'b1;
      pins(6'b010101, "pins at reset");
      rdchk(OFS_CTRL0, 32'h0, "ctrl0 reset");
      rdchk(OFS_DIR, 32'h7, "dir reset");
      apb(1'b0, OFS_STAT, 32'h0, 4'hf);
      chk({31'h0, rd[B_ST_KNOWN]}, 32'h0, "known flag");
      apb(1'b0, 8'h3c, 32'h0, 4'hf);
      chk({31'h0, err}, 32'h1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
      // Direction bits still tristate: levels follow, oe_n holds off
      wr(OFS_CTRL0, 32'h8e);
      idle(4);
      pins(6'b110101, "tristated pins");
      rdchk(OFS_CTRL0, 32'h8c, "pulse bits read");
      apb(1'b0, OFS_STAT, 32'h0, 4'hf);
      chk({30'h0, rd[1:0]}, 32'h3, "set pulse");
      wr(OFS_DIR, 32'h0);
      idle(4);
      pins(6'b100001, "both outputs");
      rdchk(OFS_STAT, 32'hf, "status drive");
      wr(OFS_CTRL0, 32'h8f);
      idle(4);
      pins(6'b001001, "set and reset");
      wr(OFS_PINFN, 32'h1);
      idle(4);
      pins(6'b000110, "alternate pin");
      wr(OFS_CTRL0, 32'h88);
      idle(4);
      pins(6'b000101, "inverted off");
      // Strobe for the low byte absent: the write must not land
      apb(1'b1, OFS_CTRL0, 32'h0c, 4'he);
      idle(4);
      pins(6'b000101, "masked write");
      wr(OFS_CTRL0, 32'h0c);
      idle(4);
      pins(6'b010101, "latch disabled");
      wr(OFS_PINFN, 32'h0);
      // Software reset between two clock sets keeps tick alignment
      wr(OFS_CTRL1, 32'h40);
      rdchk(OFS_CTRL1, 32'h40, "ctrl1 readback");
      for (int c = 0; c < 8; c++) begin
         wr(OFS_CTRL0, {24'h0, 1'b1, 3'(c), 4'h9});
         wait_pin(1'b0, t1);
         wait_pin(1'b1, t1);
         wr(OFS_CTRL0, {24'h0, 1'b1, 3'(c), 4'h9});
         wait_pin(1'b0, t2);
         wait_pin(1'b1, t2);
         if (c == 0) begin
            // Shortest period can overlap the reset write itself
            chk({31'h0, (t2 - t1 == 4) || (t2 - t1 == 8)}, 32'h1,
                "period code 0");
         end else begin
            chk(t2 - t1, 32'h1 << (c + 2), "divider period");
         end
      end
      wr(OFS_CTRL1, 32'h04);
      wr(OFS_CTRL0, 32'hfa);
      wait_pin(1'b1, t1);
      wait_pin(1'b0, t2);
      chk({31'h0, t2 - t1 <= 512}, 32'h1, "clock reset");
      // Second reset in mid-run
      presetn <= 1'b0;
      idle(2);
      presetn <= 1'b1;
      pins(6'b010101, "pins after reset");
      rdchk(OFS_CTRL0, 32'h0, "ctrl0 after reset");
      apb(1'b0, OFS_STAT, 32'h0, 4'hf);
      chk({31'h0, rd[B_ST_KNOWN]}, 32'h0, "known after reset");
      summarize;
   end
endmodule
`default_nettype wire
